// ==== rtl/pcr_top.sv ====
// pin change detection, pad ownership and peripheral remap with axi4-lite
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

// What this block does
// - falling enable catches negative edges, sets flag
// - both enables give both edges; none off
// - flag set on enabled rising or falling edge
// - flags read zero until edge; reset zero
// - software writes only clear change flags
// - per pin pull-up enable, reset off
// - per pin pull-down enable, reset off
// - remap covers a fixed pin subset only
// - input-only remap pins never take remap outputs
// - codes 0-11 io, 29-32 input only
// - remapped peripheral unconnected until software assigns
// - fixed functions never pass through remap
// - fixed peripheral always owns its pin
// - remap output beats parallel port, port io
// - fixed output beats remap output
// - remap inputs never steer output buffers
// - remap input dead while pin analog
// - lock guards mapping against stray writes
// - port summary flag follows any change flag
// - analog select disables digital input path
module pcr_top
    import pcr_pkg::*;
#(
    parameter int NRPIO = 12,
    parameter int NRPI  = 4
)(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register bus
    input  wire pcr_axi_req_s              axi_req,
    output pcr_axi_rsp_s                   axi_rsp,
    // pads
    input  wire logic [PORT_W-1:0]         pad_in,
    output logic      [PORT_W-1:0]         pad_out,
    output logic      [PORT_W-1:0]         pad_oe,
    output logic      [PORT_W-1:0]         pad_pull_up,
    output logic      [PORT_W-1:0]         pad_pull_down,
    output logic      [PORT_W-1:0]         pad_analog_en,
    // fixed peripherals and parallel master port
    input  wire logic [PORT_W-1:0]         fixed_oe,
    input  wire logic [PORT_W-1:0]         fixed_out,
    input  wire logic [PORT_W-1:0]         pmp_oe,
    input  wire logic [PORT_W-1:0]         pmp_out,
    // remappable peripheral signals
    input  wire logic [PERIPH_OUT_N-1:0]   periph_out,
    output logic      [NPI-1:0]            periph_in,
    // change summary to the interrupt controller
    output logic                           change_summary
);

    // whole state of the block
    typedef struct packed {
        logic                          on;
        logic                          lock;
        logic                          armed;
        logic [PORT_W-1:0]             rise;
        logic [PORT_W-1:0]             fall;
        logic [PORT_W-1:0]             flag;
        logic [PORT_W-1:0]             pu;
        logic [PORT_W-1:0]             pd;
        logic [PORT_W-1:0]             ansel;
        logic [PORT_W-1:0]             lat;
        logic [PORT_W-1:0]             tris;
        logic [PORT_W-1:0]             sync1;
        logic [PORT_W-1:0]             sync2;
        logic [PORT_W-1:0]             dig;
        logic                          summary;
        logic [PORT_W-1:0][OSEL_W-1:0] omap;
        logic [NPI-1:0][ISEL_W-1:0]    imap;
        logic [PORT_W-1:0]             pout;
        logic [PORT_W-1:0]             poe;
        logic [NPI-1:0]                pin_sel;
        pcr_axi_rsp_s                  rsp;
    } pcr_state_s;

    pcr_state_s st_reg;
    pcr_state_s st_next;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] wmerge(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  strb
    );
        wmerge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction : wmerge

    // remap pin code to port pin, msb marks a valid pin
    function automatic logic [4:0] rp_to_pin(input logic [ISEL_W-1:0] code);
        logic [ISEL_W-1:0] off;
        off = code - ISEL_W'(RP_IN_BASE);
        if (code < ISEL_W'(NRPIO))
            return {1'b1, code[3:0]};
        if (code >= ISEL_W'(RP_IN_BASE) && off < ISEL_W'(NRPI))
            return {1'b1, 4'(NRPIO) + off[3:0]};
        return 5'h00;
    endfunction : rp_to_pin

    // register read decode
    function automatic logic [32:0] reg_read(
        input pcr_state_s    s,
        input logic [7:0]    a
    );
        logic [31:0] d;
        logic        ok;
        d  = 32'h0000_0000;
        ok = 1'b1;
        case (a)
            OFS_CTRL:
            begin
                d[CTRL_ON_BIT]   = s.on;
                d[CTRL_LOCK_BIT] = s.lock;
            end
            OFS_UNLOCK: d = 32'h0000_0000;
            OFS_RISE:   d[15:0] = s.rise;
            OFS_FALL:   d[15:0] = s.fall;
            OFS_FLAG:   d[15:0] = s.flag;
            OFS_PULLUP: d[15:0] = s.pu;
            OFS_PULLDN: d[15:0] = s.pd;
            OFS_ANALOG: d[15:0] = s.ansel;
            OFS_LATCH:  d[15:0] = s.lat;
            OFS_OUTDIS: d[15:0] = s.tris;
            OFS_PORTIN: d[15:0] = s.dig;
            OFS_STATUS: d[STAT_SUM_BIT] = s.summary;
            default:
            begin
                if (a >= OFS_OMAP && a < OFS_OMAP + 8'(4 * PORT_W))
                    d[OSEL_W-1:0] = s.omap[a[5:2]];
                else if (a >= OFS_IMAP && a < OFS_IMAP + 8'(4 * NPI))
                    d[ISEL_W-1:0] = s.imap[a[4:2]];
                else
                    ok = 1'b0;
            end
        endcase
        return {ok, d};
    endfunction : reg_read

    // next-state logic
    always_comb
    begin
        logic [PORT_W-1:0] events;
        logic [PORT_W-1:0] dnew;
        logic [PORT_W-1:0] clr_mask;
        logic              wr_go;
        logic              wr_ok;
        logic [7:0]        wa;
        logic [15:0]       wd16;
        logic [32:0]       rd;
        logic [4:0]        pin;
        events   = '0;
        dnew     = '0;
        clr_mask = '1;
        wr_go    = 1'b0;
        wr_ok    = 1'b1;
        wa       = 8'h00;
        wd16     = 16'h0000;
        rd       = 33'h0;
        pin      = 5'h00;
        st_next  = st_reg;

        // two-flop pad synchroniser
        // the first flop may go metastable, so only sync2 feeds logic
        st_next.sync1 = pad_in;
        st_next.sync2 = st_reg.sync1;
        dnew        = st_reg.sync2 & ~st_reg.ansel;
        st_next.dig = dnew;

        // each edge has its own enable
        // enable changes while on may glitch
        // a pin turned digital can show an edge, as dig starts from zero
        if (st_reg.on)
            events = (dnew & ~st_reg.dig & st_reg.rise)
                   | (~dnew & st_reg.dig & st_reg.fall);

        // axi write: take address and data together
        // waiting for both valids keeps address and data in step
        st_next.rsp.awready = 1'b0;
        st_next.rsp.wready  = 1'b0;
        if (axi_req.awvalid && axi_req.wvalid && !st_reg.rsp.bvalid
            && !st_reg.rsp.awready)
        begin
            st_next.rsp.awready = 1'b1;
            st_next.rsp.wready  = 1'b1;
        end
        wr_go = st_reg.rsp.awready && axi_req.awvalid && axi_req.wvalid;
        wa    = {axi_req.awaddr[7:2], 2'b00};
        wd16  = axi_req.wdata[15:0];
        if (st_reg.rsp.bvalid && axi_req.bready)
            st_next.rsp.bvalid = 1'b0;

        if (wr_go)
        begin
            case (wa)
                OFS_CTRL:
                begin
                    if (axi_req.wstrb[0])
                    begin
                        st_next.on = axi_req.wdata[CTRL_ON_BIT];
                        if (axi_req.wdata[CTRL_LOCK_BIT])
                            st_next.lock = 1'b1;
                    end
                end
                OFS_UNLOCK:
                begin
                    st_next.armed = (wd16 == KEY_ARM);
                    if (st_reg.armed && wd16 == KEY_OPEN)
                        st_next.lock = 1'b0;
                end
                OFS_RISE:
                    st_next.rise = wmerge(st_reg.rise, axi_req.wdata, axi_req.wstrb);
                OFS_FALL:
                    st_next.fall = wmerge(st_reg.fall, axi_req.wdata, axi_req.wstrb);
                OFS_FLAG:
                    clr_mask = wmerge(st_reg.flag, axi_req.wdata, axi_req.wstrb);
                OFS_PULLUP:
                    st_next.pu = wmerge(st_reg.pu, axi_req.wdata, axi_req.wstrb);
                OFS_PULLDN:
                    st_next.pd = wmerge(st_reg.pd, axi_req.wdata, axi_req.wstrb);
                OFS_ANALOG:
                    st_next.ansel = wmerge(st_reg.ansel, axi_req.wdata, axi_req.wstrb);
                OFS_LATCH:
                    st_next.lat = wmerge(st_reg.lat, axi_req.wdata, axi_req.wstrb);
                OFS_OUTDIS:
                    st_next.tris = wmerge(st_reg.tris, axi_req.wdata, axi_req.wstrb);
                OFS_PORTIN, OFS_STATUS: wr_ok = 1'b1;
                default:
                begin
                    if (wa >= OFS_OMAP && wa < OFS_OMAP + 8'(4 * PORT_W))
                    begin
                        if (!st_reg.lock && axi_req.wstrb[0])
                            st_next.omap[wa[5:2]] = axi_req.wdata[OSEL_W-1:0];
                    end
                    else if (wa >= OFS_IMAP && wa < OFS_IMAP + 8'(4 * NPI))
                    begin
                        if (!st_reg.lock && axi_req.wstrb[0])
                            st_next.imap[wa[4:2]] = axi_req.wdata[ISEL_W-1:0];
                    end
                    else
                        wr_ok = 1'b0;
                end
            endcase
            if (wa != OFS_UNLOCK)
                st_next.armed = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // software clear, new edge wins over clear
        // letting the clear win would silently lose an edge
        st_next.flag    = (st_reg.flag & clr_mask) | events;
        st_next.summary = |st_next.flag;

        // axi read: one outstanding, answer next cycle
        // read data come from the state before this edge's write
        st_next.rsp.arready = 1'b0;
        if (axi_req.arvalid && !st_reg.rsp.rvalid && !st_reg.rsp.arready)
            st_next.rsp.arready = 1'b1;
        if (st_reg.rsp.rvalid && axi_req.rready)
            st_next.rsp.rvalid = 1'b0;
        if (st_reg.rsp.arready && axi_req.arvalid)
        begin
            rd = reg_read(st_reg, {axi_req.araddr[7:2], 2'b00});
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata  = rd[31:0];
            st_next.rsp.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end

        // pad ownership per pin, highest priority first
        // an output code past PERIPH_OUT_N leaves the pin to the parallel port or port
        for (int p = 0; p < PORT_W; p++)
        begin
            if (fixed_oe[p])
            begin
                st_next.pout[p] = fixed_out[p];
                st_next.poe[p]  = 1'b1;
            end
            // remap output beats pmp and port
            else if (p < NRPIO && st_reg.omap[p] != OSEL_NONE
                     && st_reg.omap[p] <= OSEL_W'(PERIPH_OUT_N))
            begin
                st_next.pout[p] = periph_out[st_reg.omap[p] - OSEL_W'(1)];
                st_next.poe[p]  = 1'b1;
            end
            else if (pmp_oe[p])
            begin
                st_next.pout[p] = pmp_out[p];
                st_next.poe[p]  = 1'b1;
            end
            else
            begin
                st_next.pout[p] = st_reg.lat[p];
                st_next.poe[p]  = ~st_reg.tris[p];
            end
        end

        // remapped peripheral inputs
        // codes naming no pin read zero rather than a stale level
        for (int k = 0; k < NPI; k++)
        begin
            pin = rp_to_pin(st_reg.imap[k]);
            // analog pin gives zero via dnew
            st_next.pin_sel[k] = pin[4] & dnew[pin[3:0]];
        end

        // synchronous reset to defined values
        // analog and output disable start set so every pad floats safely
        if (!rst_n)
        begin
            st_next         = '0;
            st_next.flag    = RST_ZERO16;
            st_next.rise    = RST_ZERO16;
            st_next.fall    = RST_ZERO16;
            st_next.pu      = RST_ZERO16;
            st_next.pd      = RST_ZERO16;
            st_next.lat     = RST_ZERO16;
            st_next.ansel   = RST_ANALOG;
            st_next.tris    = RST_OUTDIS;
            // no default pin for any input
            for (int k = 0; k < NPI; k++)
                st_next.imap[k] = ISEL_NONE;
            for (int p = 0; p < PORT_W; p++)
                st_next.omap[p] = OSEL_NONE;
        end
    end

    // single state register
    always_ff @(posedge clk)
    begin
        st_reg <= st_next;
    end

    // outputs straight from flops
    assign axi_rsp        = st_reg.rsp;
    assign pad_out        = st_reg.pout;
    assign pad_oe         = st_reg.poe;
    assign pad_pull_up    = st_reg.pu;
    assign pad_pull_down  = st_reg.pd;
    assign pad_analog_en  = st_reg.ansel;
    assign periph_in      = st_reg.pin_sel;
    assign change_summary = st_reg.summary;

endmodule : pcr_top

// ==== rtl/pcr_pkg.sv ====
// constants and carrier types for the pin change and remap block
package pcr_pkg;

    // port and remap geometry
    localparam int PORT_W         = 16;
    localparam int NPI            = 8;
    localparam int OSEL_W         = 5;
    localparam int ISEL_W         = 6;
    localparam int RP_IO_MAX      = 29;
    localparam int RP_IN_MAX      = 4;
    localparam int RP_IN_BASE     = 29;
    localparam int RP_TOTAL_MAX   = 33;
    localparam int REMAP_PINS_MAX = 44;
    localparam int PERIPH_OUT_N   = 25;
    localparam int AXI_AW         = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_UNLOCK   = 8'h04;
    localparam logic [7:0] OFS_RISE     = 8'h08;
    localparam logic [7:0] OFS_FALL     = 8'h0c;
    localparam logic [7:0] OFS_FLAG     = 8'h10;
    localparam logic [7:0] OFS_PULLUP   = 8'h14;
    localparam logic [7:0] OFS_PULLDN   = 8'h18;
    localparam logic [7:0] OFS_ANALOG   = 8'h1c;
    localparam logic [7:0] OFS_LATCH    = 8'h20;
    localparam logic [7:0] OFS_OUTDIS   = 8'h24;
    localparam logic [7:0] OFS_PORTIN   = 8'h28;
    localparam logic [7:0] OFS_STATUS   = 8'h2c;
    localparam logic [7:0] OFS_OMAP     = 8'h40;
    localparam logic [7:0] OFS_IMAP     = 8'h80;

    // field positions
    localparam int CTRL_ON_BIT   = 0;
    localparam int CTRL_LOCK_BIT = 1;
    localparam int STAT_SUM_BIT  = 0;

    // reset values and codes
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [15:0] RST_ANALOG = 16'hffff;
    localparam logic [15:0] RST_OUTDIS = 16'hffff;
    localparam logic [15:0] KEY_ARM    = 16'h0055;
    localparam logic [15:0] KEY_OPEN   = 16'h00aa;
    localparam logic [4:0]  OSEL_NONE  = 5'h00;
    localparam logic [5:0]  ISEL_NONE  = 6'h3f;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // axi4-lite request from master
    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } pcr_axi_req_s;

    // axi4-lite response to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pcr_axi_rsp_s;

endpackage : pcr_pkg

// ==== dv/pcr_monitor.sv ====
// concurrent checks on the ports of the pin change and remap block
`timescale 1ns/1ns
module pcr_monitor
    import pcr_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // register bus
    input wire pcr_axi_req_s      axi_req,
    input wire pcr_axi_rsp_s      axi_rsp,
    // pad side
    input wire logic [PORT_W-1:0] pad_out,
    input wire logic [PORT_W-1:0] pad_oe,
    input wire logic [PORT_W-1:0] pad_pull_up,
    input wire logic [PORT_W-1:0] pad_pull_down,
    input wire logic [PORT_W-1:0] pad_analog_en,
    input wire logic [PORT_W-1:0] fixed_oe,
    input wire logic [PORT_W-1:0] fixed_out,
    input wire logic              change_summary
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // reset must be seen even while reset is low, so no disable here
    reset_vals_a:
        assert property (disable iff (1'b0) !rst_n |=> pad_analog_en == 16'hffff
            && pad_oe == 16'h0000 && pad_pull_up == 16'h0000
            && pad_pull_down == 16'h0000 && !change_summary) else $error("bad reset outputs");

    // a fixed peripheral owns its pad one cycle later
    fixed_own_a:
        assert property (rst_n |=> (pad_oe & $past(fixed_oe)) == $past(fixed_oe))
            else $error("fixed pad not driven");
    fixed_val_a:
        assert property (rst_n |=> ((pad_out ^ $past(fixed_out)) & $past(fixed_oe)) == 16'h0000)
            else $error("fixed pad value lost");

    // flags only drop through a register write
    flag_clear_a:
        assert property ($fell(change_summary) |-> $past(axi_rsp.awready)
            || $past(axi_rsp.awready, 2)) else $error("summary fell without a write");

    // bus handshakes follow the hand-over timing
    wr_resp_a:
        assert property (axi_rsp.awready |=> axi_rsp.bvalid && !axi_rsp.awready)
            else $error("write response late");
    rd_resp_a:
        assert property (axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
            else $error("read response late");
    ready_pair_a:
        assert property (axi_rsp.awready |-> axi_rsp.wready && $past(axi_req.awvalid)
            && $past(axi_req.wvalid)) else $error("write ready without request");
    ar_cause_a:
        assert property (axi_rsp.arready |-> $past(axi_req.arvalid))
            else $error("read ready without request");
    wr_drop_a:
        assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
            else $error("write response repeated");
    rd_drop_a:
        assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
            else $error("read response repeated");

    // main scenarios reached
    cover property ($rose(change_summary));
    cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
    cover property (fixed_oe != 16'h0000);
endmodule : pcr_monitor

bind pcr_top pcr_monitor u_monitor (
    .clk            (clk),
    .rst_n          (rst_n),
    .axi_req        (axi_req),
    .axi_rsp        (axi_rsp),
    .pad_out        (pad_out),
    .pad_oe         (pad_oe),
    .pad_pull_up    (pad_pull_up),
    .pad_pull_down  (pad_pull_down),
    .pad_analog_en  (pad_analog_en),
    .fixed_oe       (fixed_oe),
    .fixed_out      (fixed_out),
    .change_summary (change_summary)
);

// ==== dv/pcr_pad_model.sv ====
// far-side pad model: loopback, pulls, external drivers, floating churn
`timescale 1ns/1ns
module pcr_pad_model
    import pcr_pkg::*;
(
    // clock
    input wire logic               clk,
    // block pad side
    input wire logic [PORT_W-1:0]  pad_out,
    input wire logic [PORT_W-1:0]  pad_oe,
    input wire logic [PORT_W-1:0]  pad_pull_up,
    input wire logic [PORT_W-1:0]  pad_pull_down,
    // external drivers set by the bench
    input wire logic [PORT_W-1:0]  ext_en,
    input wire logic [PORT_W-1:0]  ext_val,
    // resolved pad level
    output logic      [PORT_W-1:0] pad_in
);
    // a floating pad wanders so a stale level never passes for a real one
    logic [PORT_W-1:0] churn = 16'h5a5a;

    always @(posedge clk)
        churn <= ~churn;

    assign pad_in = (pad_oe & pad_out)
        | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & pad_pull_up)
        | (~pad_oe & ~ext_en & ~pad_pull_up & ~pad_pull_down & churn);
endmodule : pcr_pad_model

// ==== dv/pin_change_detect_and_remap_tb.sv ====
// self-checking bench for the pin change and remap block
`timescale 1ns/1ns
module pin_change_detect_and_remap_tb
    import pcr_pkg::*;
;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    pcr_axi_req_s            req = '0;
    pcr_axi_rsp_s            rsp;
    logic [PORT_W-1:0]       pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_an;
    logic [PORT_W-1:0]       fix_oe = '0, fix_out = '0, pmp_oe = '0, pmp_out = '0;
    logic [PORT_W-1:0]       ext_en = '0, ext_val = '0;
    logic [PERIPH_OUT_N-1:0] periph_out = '0;
    logic [NPI-1:0]          periph_in;
    logic                    summary;
    logic [33:0]             expq[$];
    logic [31:0]             r;
    logic [7:0]              ofs[8] = '{OFS_CTRL, OFS_RISE, OFS_FALL, OFS_FLAG,
                                        OFS_PULLUP, OFS_PULLDN, OFS_ANALOG, OFS_OUTDIS};
    logic [15:0]             rv[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                       16'h0000, 16'h0000, RST_ANALOG, RST_OUTDIS};
    int                      fail_count = 0;
    int                      tests_run = 0;
    int                      cycles = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    pcr_top #(.NRPIO(12), .NRPI(4)) dut (
        .clk(clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu), .pad_pull_down(pad_pd),
        .pad_analog_en(pad_an), .fixed_oe(fix_oe), .fixed_out(fix_out), .pmp_oe(pmp_oe),
        .pmp_out(pmp_out), .periph_out(periph_out), .periph_in(periph_in),
        .change_summary(summary));

    pcr_pad_model model (
        .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu),
        .pad_pull_down(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    task automatic cmp(input string name, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", name, e, g);
            fail_count++;
        end
    endtask : cmp

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // write cycle: both channels offered together, response awaited
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {16'h0000, d};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do @(posedge clk); while (rsp.awready !== 1'b1);
        req.awvalid <= 1'b0;
        req.wvalid  <= 1'b0;
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        cmp("bresp", {32'h0, er}, {32'h0, rsp.bresp});
    endtask : wr

    // read cycle: expectation noted first, the watcher compares it
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
        @(posedge clk);
        expq.push_back({er, 16'h0000, e});
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
    endtask : rd

    // read data watcher takes the oldest note on each accepted beat
    always @(posedge clk)
    begin
        if (rst_n && rsp.rvalid && req.rready)
        begin
            if (expq.size() == 0)
                cmp("read note", 34'h0, 34'h1);
            else
                cmp("read", expq.pop_front(), {rsp.rresp, rsp.rdata});
        end
    end

    // hang guard well above the expected run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'hf2e70e94));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(ofs[i], rv[i]);
        rd(8'h30, 16'h0000, RESP_SLVERR);
        wr(8'h30, 16'h1234, RESP_SLVERR);
        r = $urandom;
        wr(OFS_PULLUP, r[15:0]);
        wr(OFS_PULLDN, r[31:16]);
        rd(OFS_PULLUP, r[15:0]);
        rd(OFS_PULLDN, r[31:16]);
        cmp("pull up", {18'h0, r[15:0]}, {18'h0, pad_pu});
        cmp("pull down", {18'h0, r[31:16]}, {18'h0, pad_pd});
        // pads other than 12 driven low, digital on; detection off while enables move
        wr(OFS_LATCH, 16'h0000);
        wr(OFS_OUTDIS, 16'h1000);
        wr(OFS_ANALOG, 16'h0000);
        wr(OFS_RISE, 16'h0005);
        wr(OFS_FALL, 16'h0006);
        wr(OFS_CTRL, 16'h0001);
        rd(OFS_FLAG, 16'h0000);
        wr(OFS_LATCH, 16'h000f);
        repeat (8) @(posedge clk);
        cmp("summary", 34'h1, {33'h0, summary});
        rd(OFS_FLAG, 16'h0005);
        rd(OFS_STATUS, 16'h0001);
        wr(OFS_FLAG, 16'h0000);
        rd(OFS_FLAG, 16'h0000);
        wr(OFS_LATCH, 16'h0000);
        repeat (8) @(posedge clk);
        rd(OFS_FLAG, 16'h0006);
        wr(OFS_FLAG, 16'hfffb);
        rd(OFS_FLAG, 16'h0002);
        wr(OFS_FLAG, 16'h0000);
        rd(OFS_STATUS, 16'h0000);
        // pad 5 ownership: parallel port, then remap, then fixed
        r = $urandom;
        periph_out <= r[24:0];
        pmp_out    <= {16{~r[2]}};
        pmp_oe     <= 16'h0020;
        repeat (2) @(posedge clk);
        cmp("pmp pad", {33'h0, ~r[2]}, {33'h0, pad_out[5]});
        wr(OFS_OMAP + 8'h14, 16'h0003);
        repeat (2) @(posedge clk);
        cmp("remap pad", {32'h0, 1'b1, r[2]}, {32'h0, pad_oe[5], pad_out[5]});
        fix_oe  <= 16'h0020;
        fix_out <= {16{~r[2]}};
        repeat (2) @(posedge clk);
        cmp("fixed pad", {33'h0, ~r[2]}, {33'h0, pad_out[5]});
        fix_oe <= 16'h0000;
        // input-only pad 12 never drives, but feeds a remapped input
        wr(OFS_OMAP + 8'h30, 16'h0003);
        ext_en  <= 16'h1000;
        ext_val <= 16'h1000;
        wr(OFS_IMAP + 8'h04, 16'h001d);
        repeat (6) @(posedge clk);
        cmp("input only oe", 34'h0, {33'h0, pad_oe[12]});
        cmp("remap input", 34'h1, {32'h0, periph_in[2:1]});
        wr(OFS_ANALOG, 16'h1000);
        repeat (6) @(posedge clk);
        cmp("analog pad", 34'h1000, {18'h0, pad_an});
        cmp("analog input", 34'h0, {33'h0, periph_in[1]});
        rd(OFS_PORTIN, {10'h0, r[2], 5'h0});
        // mapping lock and two-step unlock
        wr(OFS_CTRL, 16'h0003);
        wr(OFS_OMAP + 8'h18, 16'h0003);
        rd(OFS_OMAP + 8'h18, 16'h0000);
        wr(OFS_UNLOCK, KEY_ARM);
        wr(OFS_UNLOCK, KEY_OPEN);
        wr(OFS_OMAP + 8'h18, 16'h0003);
        rd(OFS_OMAP + 8'h18, 16'h0003);
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule : pin_change_detect_and_remap_tb
